// >>> rtl/nand_host_pkg.sv
// Purpose: Shared constants, types and helpers for the NAND flash host controller
// Assumes: 200 MHz system clock, one device on the bus
// Notes:   Pin timing figures are plain defaults, to be tuned to the part in use
package nand_host_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int T_STROBE_NS = 25;      // Least low and least high time of a strobe
    localparam int T_WB_NS = 100;         // Longest time from last strobe to busy going low
    localparam int STROBE_CYC = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WB_CYC = (T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ADDR_CYCLES = 5;

    ////////////////////////////////////////////////////////////////////////////
    // Command codes
    localparam logic [7:0] CMD_READ = 8'h00;
    localparam logic [7:0] CMD_READ_GO = 8'h30;
    localparam logic [7:0] CMD_READ_CPY = 8'h35;
    localparam logic [7:0] CMD_ID = 8'h90;
    localparam logic [7:0] CMD_RESET = 8'hff;
    localparam logic [7:0] CMD_PROG = 8'h80;
    localparam logic [7:0] CMD_CPY_PROG = 8'h85;
    localparam logic [7:0] CMD_PROG_GO = 8'h10;
    localparam logic [7:0] CMD_PLANE_NEXT = 8'h11;
    localparam logic [7:0] CMD_PLANE2 = 8'h81;
    localparam logic [7:0] CMD_ERASE = 8'h60;
    localparam logic [7:0] CMD_ERASE_GO = 8'hd0;
    localparam logic [7:0] CMD_STATUS = 8'h70;
    localparam logic [7:0] CMD_COL_OUT = 8'h05;
    localparam logic [7:0] CMD_COL_OUT_GO = 8'he0;
    localparam logic [7:0] CMD_CACHE = 8'h31;
    localparam logic [7:0] CMD_CACHE_END = 8'h3f;
    localparam logic [7:0] CMD_EDC_STATUS = 8'h7b;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [2:0] {OP_CMD, OP_ADDR, OP_WRITE, OP_READ, OP_WAIT} op_t;

    typedef struct packed {
        op_t op;
        logic [7:0] code;     // Command code for OP_CMD
        logic [11:0] col;     // Column for OP_ADDR
        logic [16:0] row;     // Page and block for OP_ADDR
        logic [11:0] count;   // Words for OP_WRITE and OP_READ, at least one
    } req_t;

    typedef struct packed {
        logic ceN;
        logic cle;
        logic ale;
        logic weN;
        logic reN;
        logic wpN;
    } pins_t;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    // Address byte of a given cycle; unused positions are low
    function automatic logic [7:0] addrByte(input logic [2:0] idx, input logic [11:0] col,
                                            input logic [16:0] row, input logic wide);
        logic [7:0] b;
        b = 8'h00;
        unique case (idx)
            3'h0: b = col[7:0];
            3'h1: b = wide ? {5'h00, col[10:8]} : {4'h0, col[11:8]};
            3'h2: b = row[7:0];
            3'h3: b = row[15:8];
            3'h4: b = {7'h00, row[16]};
            default: b = 8'h00;
        endcase
        return b;
    endfunction

    // Codes that lead to a program or an erase
    function automatic logic isModifying(input logic [7:0] c);
        return c == CMD_PROG || c == CMD_CPY_PROG || c == CMD_PROG_GO || c == CMD_PLANE_NEXT
            || c == CMD_PLANE2 || c == CMD_ERASE || c == CMD_ERASE_GO;
    endfunction

    // Codes that a busy device still takes
    function automatic logic busyOk(input logic [7:0] c);
        return c == CMD_RESET || c == CMD_STATUS;
    endfunction

endpackage

// >>> rtl/nand_pair_buffer.sv
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: Single clock, synchronous active-high reset
// Notes:   Full throughput; a stalled reader makes inReady fall after two words
`timescale 1ns/1ps
`default_nettype none
module nand_pair_buffer #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Filling side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Draining side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    logic [WIDTH-1:0] mem [2];
    logic wrPtr;
    logic rdPtr;
    logic [1:0] fill;
    logic push;
    logic pop;

    ////////////////////////////////////////////////////////////////////////////
    // Handshakes
    assign push = inValid && inReady;
    assign pop = outValid && outReady;
    assign inReady = fill != 2'h2;   // Honest full
    assign outValid = fill != 2'h0;  // Honest empty
    assign outData = mem[rdPtr];

    // Storage
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wrPtr] <= inData;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wrPtr <= 1'b0;
            rdPtr <= 1'b0;
            fill <= 2'h0;
        end
        else
        begin
            if (push)
                wrPtr <= ~wrPtr;
            if (pop)
                rdPtr <= ~rdPtr;
            if (push && !pop)
                fill <= fill + 2'h1;
            else if (pop && !push)
                fill <= fill - 2'h1;
        end
    end

    a_fill_bound: assert property (@(posedge clk) disable iff (rst) fill <= 2'h2)
        else $error("Buffer fill level out of range");

endmodule // nand_pair_buffer
`default_nettype wire

// >>> rtl/nand_host_ctrl.sv
// Purpose: Host controller that drives a NAND flash through its bus pins
// Assumes: One device; WIDE selects the word-wide organisation
// Notes:   Rules carried out by this block follow
// Operation
// - Byte-wide address: five cycles, column then row
// - Word-wide address: five cycles, upper lines unused
// - Unused address bit positions driven low
// - Command: CLE high, ALE low, RE high
// - Address: ALE high, CLE low, five cycles
// - Data in needs latches low, protect high
// - Data out on RE falling, WE high
// - Busy wait: latches, CE low, strobes high
// - Command and address on lowest eight lines
`timescale 1ns/1ps
`default_nettype none
module nand_host_ctrl #(
    parameter bit WIDE = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Orders
    input wire logic reqValid,
    output logic reqReady,
    input wire nand_host_pkg::req_t req,
    output logic opDone,
    input wire logic protect,
    output logic deviceReady,
    // Write data
    input wire logic wrValid,
    output logic wrReady,
    input wire logic [15:0] wrData,
    // Read data
    output logic rdValid,
    input wire logic rdReady,
    output logic [15:0] rdData,
    // Device pins
    output nand_host_pkg::pins_t nandCtl,
    output logic [15:0] ioOut,
    output logic ioOe,
    input wire logic [15:0] ioIn,
    input wire logic readyBusyIn
);
    typedef enum {ST_IDLE, ST_FETCH, ST_LOW, ST_HIGH, ST_WAITWB, ST_WAITRB} state_t;

    state_t state;
    state_t next_state;
    nand_host_pkg::req_t cur;
    logic [11:0] itemIdx;
    logic [7:0] phaseCnt;
    logic [7:0] wbCnt;
    logic tick;
    logic lastItem;
    logic canGo;
    logic accept;
    logic refuse;
    logic rbMeta;
    logic rbSync;
    logic [15:0] ioMeta;
    logic [15:0] ioSync;
    logic bufInValid;
    logic bufInReady;
    logic [15:0] bufInData;
    logic cpyCtx;
    logic cacheCtx;
    logic [7:0] lastCode;

    ////////////////////////////////////////////////////////////////////////////
    // Pin input synchronisers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rbMeta <= 1'b0;
            rbSync <= 1'b0;
            ioMeta <= 16'h0000;
            ioSync <= 16'h0000;
        end
        else
        begin
            rbMeta <= readyBusyIn;
            rbSync <= rbMeta;
            ioMeta <= ioIn;
            ioSync <= ioMeta;
        end
    end
    assign deviceReady = rbSync;

    ////////////////////////////////////////////////////////////////////////////
    // Order acceptance; refused codes simply hold reqReady low
    always_comb
    begin
        refuse = 1'b0;
        if (req.op == nand_host_pkg::OP_CMD)
        begin
            if (!rbSync && !nand_host_pkg::busyOk(req.code))
                refuse = 1'b1;
            if (protect && nand_host_pkg::isModifying(req.code))
                refuse = 1'b1;
            if (req.code == nand_host_pkg::CMD_EDC_STATUS && !cpyCtx)
                refuse = 1'b1;
            if (req.code == nand_host_pkg::CMD_CACHE
                && !(lastCode == nand_host_pkg::CMD_READ || cacheCtx))
                refuse = 1'b1;
        end
        else if (req.op == nand_host_pkg::OP_WRITE && protect)
            refuse = 1'b1;
    end
    assign reqReady = state == ST_IDLE && !refuse;
    assign accept = reqValid && reqReady;

    // Command context: copy-back and cache reading sequences
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cpyCtx <= 1'b0;
            cacheCtx <= 1'b0;
            lastCode <= nand_host_pkg::CMD_RESET;
        end
        else if (accept && req.op == nand_host_pkg::OP_CMD)
        begin
            lastCode <= req.code;
            if (req.code == nand_host_pkg::CMD_READ_CPY || req.code == nand_host_pkg::CMD_CPY_PROG)
                cpyCtx <= 1'b1;
            else if (req.code == nand_host_pkg::CMD_PROG || req.code == nand_host_pkg::CMD_ERASE
                     || req.code == nand_host_pkg::CMD_RESET
                     || req.code == nand_host_pkg::CMD_READ_GO)
                cpyCtx <= 1'b0;
            if (req.code == nand_host_pkg::CMD_CACHE)
                cacheCtx <= 1'b1;
            else if (req.code == nand_host_pkg::CMD_CACHE_END
                     || req.code == nand_host_pkg::CMD_RESET)
                cacheCtx <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    assign tick = phaseCnt == 8'(nand_host_pkg::STROBE_CYC - 1);
    always_comb
    begin
        unique case (cur.op)
            nand_host_pkg::OP_CMD: lastItem = 1'b1;
            nand_host_pkg::OP_ADDR: lastItem = itemIdx == 12'(nand_host_pkg::ADDR_CYCLES - 1);
            default: lastItem = itemIdx + 12'h001 >= cur.count;
        endcase
    end
    // Data items wait for a word to send or room to store one
    always_comb
    begin
        unique case (cur.op)
            nand_host_pkg::OP_WRITE: canGo = wrValid;
            nand_host_pkg::OP_READ: canGo = bufInReady;
            default: canGo = 1'b1;
        endcase
    end
    assign wrReady = state == ST_FETCH && cur.op == nand_host_pkg::OP_WRITE;

    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_IDLE:
                if (accept)
                    next_state = (req.op == nand_host_pkg::OP_WAIT) ? ST_WAITWB : ST_FETCH;
            ST_FETCH:
                if (canGo)
                    next_state = ST_LOW;
            ST_LOW:
                if (tick)
                    next_state = ST_HIGH;
            ST_HIGH:
                if (tick)
                    next_state = lastItem ? ST_IDLE : ST_FETCH;
            ST_WAITWB:
                if (wbCnt == 8'(nand_host_pkg::WB_CYC - 1))
                    next_state = ST_WAITRB;
            ST_WAITRB:
                if (rbSync)
                    next_state = ST_IDLE;
        endcase
    end
    assign opDone = (state == ST_HIGH && tick && lastItem) || (state == ST_WAITRB && rbSync);

    // State, order and counters
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state <= ST_IDLE;
            cur <= '0;
            itemIdx <= 12'h000;
            phaseCnt <= 8'h00;
            wbCnt <= 8'h00;
        end
        else
        begin
            state <= next_state;
            if (accept)
                cur <= req;
            if (state == ST_IDLE)
                itemIdx <= 12'h000;
            else if (state == ST_HIGH && tick)
                itemIdx <= itemIdx + 12'h001;
            // Strobe phase divider: one tick per half period
            if ((state == ST_LOW || state == ST_HIGH) && !tick)
                phaseCnt <= phaseCnt + 8'h01;
            else
                phaseCnt <= 8'h00;
            wbCnt <= (state == ST_WAITWB) ? wbCnt + 8'h01 : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive, all from flops so no glitch reaches the strobes
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            nandCtl <= '{ceN: 1'b1, cle: 1'b0, ale: 1'b0, weN: 1'b1, reN: 1'b1, wpN: 1'b0};
            ioOut <= 16'h0000;
            ioOe <= 1'b0;
        end
        else
        begin
            nandCtl.wpN <= !protect;
            unique case (next_state)
                ST_IDLE:
                begin
                    nandCtl.ceN <= 1'b1;
                    nandCtl.cle <= 1'b0;
                    nandCtl.ale <= 1'b0;
                    nandCtl.weN <= 1'b1;
                    nandCtl.reN <= 1'b1;
                    ioOe <= 1'b0;
                end
                ST_FETCH, ST_HIGH:
                begin
                    // Rising strobe; latches and data held across the edge
                    nandCtl.ceN <= 1'b0;
                    nandCtl.weN <= 1'b1;
                    nandCtl.reN <= 1'b1;
                end
                ST_LOW:
                begin
                    nandCtl.ceN <= 1'b0;
                    nandCtl.cle <= cur.op == nand_host_pkg::OP_CMD;
                    nandCtl.ale <= cur.op == nand_host_pkg::OP_ADDR;
                    nandCtl.weN <= cur.op == nand_host_pkg::OP_READ;
                    nandCtl.reN <= cur.op != nand_host_pkg::OP_READ;
                    ioOe <= cur.op != nand_host_pkg::OP_READ;
                    if (state == ST_FETCH)
                    begin
                        unique case (cur.op)
                            nand_host_pkg::OP_CMD:
                                ioOut <= {8'h00, cur.code};
                            nand_host_pkg::OP_ADDR:
                                ioOut <= {8'h00, nand_host_pkg::addrByte(itemIdx[2:0], cur.col,
                                          cur.row, WIDE)};
                            default:
                                ioOut <= WIDE ? wrData : {8'h00, wrData[7:0]};
                        endcase
                    end
                end
                ST_WAITWB, ST_WAITRB:
                begin
                    nandCtl.ceN <= 1'b0;
                    nandCtl.cle <= 1'b0;
                    nandCtl.ale <= 1'b0;
                    nandCtl.weN <= 1'b1;
                    nandCtl.reN <= 1'b1;
                    ioOe <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path: word sampled late in the RE low phase, after the sync delay
    assign bufInValid = state == ST_LOW && tick && cur.op == nand_host_pkg::OP_READ;
    assign bufInData = WIDE ? ioSync : {8'h00, ioSync[7:0]};

    nand_pair_buffer #(.WIDTH(16)) readBuf (
        .clk(clk),
        .rst(rst),
        .inValid(bufInValid),
        .inReady(bufInReady),
        .inData(bufInData),
        .outValid(rdValid),
        .outReady(rdReady),
        .outData(rdData)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_cmd_latch_pins: assert property (@(posedge clk) disable iff (rst)
        nandCtl.cle |-> !nandCtl.ale && nandCtl.reN && !nandCtl.ceN)
        else $error("Command latch with bad control pins");
    a_addr_latch_pins: assert property (@(posedge clk) disable iff (rst)
        nandCtl.ale |-> !nandCtl.cle && nandCtl.reN && ioOut[15:8] == 8'h00)
        else $error("Address latch with bad control pins");
    a_addr_fifth_zero: assert property (@(posedge clk) disable iff (rst)
        nandCtl.ale && !nandCtl.weN && itemIdx == 12'h004 |-> ioOut[7:1] == 7'h00)
        else $error("Fifth address cycle has stray bits");
    a_data_in_wp: assert property (@(posedge clk) disable iff (rst)
        !nandCtl.weN && !nandCtl.cle && !nandCtl.ale |-> nandCtl.wpN)
        else $error("Data input strobe with protect low");
    a_read_we_high: assert property (@(posedge clk) disable iff (rst)
        !nandCtl.reN |-> nandCtl.weN && !nandCtl.cle && !nandCtl.ale && !nandCtl.ceN)
        else $error("Read strobe with bad control pins");
    a_busy_cmd_filter: assert property (@(posedge clk) disable iff (rst)
        accept && req.op == nand_host_pkg::OP_CMD && !rbSync
        |-> nand_host_pkg::busyOk(req.code))
        else $error("Command sent while device busy");
    a_edc_context: assert property (@(posedge clk) disable iff (rst)
        accept && req.op == nand_host_pkg::OP_CMD && req.code == nand_host_pkg::CMD_EDC_STATUS
        |-> cpyCtx)
        else $error("Error detection status read outside copy-back");
    a_addr_five_cycles: assert property (@(posedge clk) disable iff (rst)
        accept && req.op == nand_host_pkg::OP_ADDR
        |-> ##[40:60] opDone && itemIdx == 12'h004)
        else $error("Address did not finish in five cycles");
    a_wait_pins: assert property (@(posedge clk) disable iff (rst)
        state == ST_WAITRB |-> !nandCtl.ceN && nandCtl.weN && nandCtl.reN && !ioOe)
        else $error("Busy wait with bad control pins");

    c_cmd_sent: cover property (@(posedge clk) disable iff (rst)
        opDone && cur.op == nand_host_pkg::OP_CMD);
    c_read_stall: cover property (@(posedge clk) disable iff (rst)
        state == ST_FETCH && cur.op == nand_host_pkg::OP_READ && !bufInReady);
    c_busy_done: cover property (@(posedge clk) disable iff (rst)
        state == ST_WAITRB ##1 state == ST_IDLE);

endmodule // nand_host_ctrl
`default_nettype wire

// >>> sim/nand_dev_model.sv
// Purpose: Behavioural NAND device on the far side of the host controller
// Assumes: Byte-wide part, busy time cut short for simulation
// Notes:   Released io lines show the inverse of the last word driven
`timescale 1ns/1ps
`default_nettype none
module nand_dev_model #(
    parameter int BUSY_NS = 300,
    parameter logic [7:0] ID_CODE = 8'h3c, // Arbitrary value
    parameter logic [7:0] STAT = 8'he0
) (
    // Host pins
    input wire nand_host_pkg::pins_t ctl,
    input wire logic [15:0] io,
    // Device outputs
    output logic [15:0] ioDrive,
    output logic rb
);
    logic [7:0] lastCmd = 8'h00;
    logic [7:0] mode = 8'h00;
    logic [39:0] addrBytes = 40'h0;
    logic [11:0] col = 12'h000;
    logic [15:0] lastWord = 16'h0000;
    logic [15:0] dout = 16'h0000;
    logic upperSeen = 1'b0;
    int aIdx = 0;
    int wrCount = 0;
    int reFalls = 0;

    initial rb = 1'b1;

    // Busy pulses may overlap; a later one can end early, which the host tolerates
    task automatic goBusy();
        rb = 1'b0;
        fork
            #(BUSY_NS) rb = 1'b1;
        join_none
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Latching on the rising write strobe
    always @(posedge ctl.weN)
    begin
        if (!ctl.ceN && ctl.reN)
        begin
            if (ctl.cle || ctl.ale)
                upperSeen <= upperSeen | (|io[15:8]);
            if (ctl.cle && !ctl.ale && (rb || io[7:0] inside {8'hff, 8'h70}))
            begin
                lastCmd <= io[7:0];
                aIdx <= 0;
                mode <= (io[7:0] inside {8'h70, 8'h90, 8'h7b}) ? io[7:0] : 8'h00;
                if (io[7:0] inside {8'h30, 8'h35, 8'h31, 8'h3f, 8'hff})
                    goBusy();
                if (ctl.wpN && io[7:0] inside {8'h10, 8'hd0})
                    goBusy();
            end
            else if (ctl.ale && !ctl.cle && aIdx < 5)
            begin
                addrBytes[aIdx*8 +: 8] <= io[7:0];
                aIdx <= aIdx + 1;
                if (aIdx == 0)
                    col[7:0] <= io[7:0];
                if (aIdx == 1)
                    col[11:8] <= io[3:0];
            end
            else if (!ctl.cle && !ctl.ale && ctl.wpN)
            begin
                wrCount <= wrCount + 1;
                lastWord <= io;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output on the falling read strobe, column advancing after each word except in modes 70 and 90
    always @(negedge ctl.reN)
    begin
        if (!ctl.ceN && ctl.weN)
        begin
            reFalls <= reFalls + 1;
            case (mode)
                8'h70: dout <= {8'h00, STAT};
                8'h90: dout <= {8'h00, ID_CODE};
                default:
                begin
                    dout <= {8'h00, col[7:0] ^ 8'ha5};
                    col <= col + 12'h001;
                end
            endcase
        end
    end

    // Deselected or idle: lines float, shown as the inverse of the last word
    assign ioDrive = (!ctl.ceN && !ctl.reN) ? dout : ~dout;
endmodule // nand_dev_model
`default_nettype wire

// >>> sim/tb_top.sv
// Purpose: Self-checking bench for the NAND host controller
// Assumes: Byte-wide device model, 200 MHz clock
// Notes:   Orders go through run; refusals are offered for ten cycles
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic reqValid = 1'b0;
    nand_host_pkg::req_t req = '0;
    logic protect = 1'b0;
    logic wrValid = 1'b0;
    logic [15:0] wrData = 16'h0000;
    logic rdReady = 1'b1;
    logic reqReady, opDone, deviceReady, wrReady, rdValid, ioOe, rb, took;
    logic [15:0] rdData, ioOut, ioDrive, ioBus;
    nand_host_pkg::pins_t nandCtl;
    logic [15:0] got [$];
    logic [7:0] codes [23] = '{8'hff, 8'h90, 8'h70, 8'h00, 8'h30, 8'h00, 8'h35, 8'h7b,
        8'h05, 8'he0, 8'h00, 8'h31, 8'h31, 8'h3f, 8'h85, 8'h11, 8'h81, 8'h10, 8'h80,
        8'h10, 8'h60, 8'h60, 8'hd0};
    int fails = 0;
    int checks_done = 0;
    int k;
    int base;

    always #2.5 clk = ~clk;

    // Io wire: host wins while it drives, otherwise the device side
    assign ioBus = ioOe ? ioOut : ioDrive;

    nand_host_ctrl #(.WIDE(1'b0)) dut (.clk(clk), .rst(rst), .reqValid(reqValid),
        .reqReady(reqReady), .req(req), .opDone(opDone), .protect(protect),
        .deviceReady(deviceReady), .wrValid(wrValid), .wrReady(wrReady), .wrData(wrData),
        .rdValid(rdValid), .rdReady(rdReady), .rdData(rdData), .nandCtl(nandCtl),
        .ioOut(ioOut), .ioOe(ioOe), .ioIn(ioBus), .readyBusyIn(rb));

    nand_dev_model dev (.ctl(nandCtl), .io(ioBus), .ioDrive(ioDrive), .rb(rb));

    // Collect read words; advance write data on each taken word
    always @(posedge clk)
    begin
        if (rdValid && rdReady)
            got.push_back(rdData);
        if (wrValid && wrReady)
            wrData <= wrData + 16'h0001;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Tasks
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // A bounded wait that ran out counts as a mismatch and ends the run
    task automatic stuck(input int i);
        if (i >= 4000)
        begin
            check(40'h0, 40'h1);
            test_done();
        end
    endtask

    task automatic run(input nand_host_pkg::op_t op, input logic [7:0] code,
                       input logic [11:0] c, input logic [16:0] r, input logic [11:0] n);
        int i;
        @(posedge clk);
        req <= '{op, code, c, r, n};
        reqValid <= 1'b1;
        @(negedge clk);
        for (i = 0; i < 4000 && reqReady !== 1'b1; i++)
            @(negedge clk);
        stuck(i);
        @(posedge clk);
        reqValid <= 1'b0;
        for (i = 0; i < 4000 && opDone !== 1'b1; i++)
            @(negedge clk);
        stuck(i);
    endtask

    task automatic cmd(input logic [7:0] code);
        run(nand_host_pkg::OP_CMD, code, 12'h000, 17'h00000, 12'h000);
    endtask

    task automatic waitReady();
        run(nand_host_pkg::OP_WAIT, 8'h00, 12'h000, 17'h00000, 12'h000);
    endtask

    // Offer an order for ten cycles; took tells whether it was ever taken
    task automatic refused(input nand_host_pkg::op_t op, input logic [7:0] code);
        @(posedge clk);
        took = 1'b0;
        req <= '{op, code, 12'h000, 17'h00000, 12'h001};
        reqValid <= 1'b1;
        repeat (10)
        begin
            @(negedge clk);
            took = took | (reqReady !== 1'b0);
        end
        @(posedge clk);
        reqValid <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        check(40'(nandCtl), 40'h26);
        check(40'(ioOe), 40'h0);
        @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        $display("test reset done");

        foreach (codes[i])
        begin
            cmd(codes[i]);
            check(40'(dev.lastCmd), 40'(codes[i]));
            waitReady();
        end
        $display("test command set done");

        cmd(8'h00);
        run(nand_host_pkg::OP_ADDR, 8'h00, 12'ha5c, 17'h12345, 12'h000);
        check(dev.addrBytes, 40'h0123450a5c);
        check(40'(dev.upperSeen), 40'h0);
        cmd(8'h30);
        waitReady();
        got.delete();
        run(nand_host_pkg::OP_READ, 8'h00, 12'h000, 17'h00000, 12'h003);
        repeat (4) @(posedge clk);
        check(40'(got.size()), 40'h3);
        for (k = 0; k < 3; k++)
            check(40'(got[k][7:0]), 40'(8'(8'h5c + k) ^ 8'ha5));
        $display("test page read done");

        // Stalled reader: two words fill the buffer, the strobe then halts
        got.delete();
        rdReady <= 1'b0;
        base = dev.reFalls;
        fork
            run(nand_host_pkg::OP_READ, 8'h00, 12'h000, 17'h00000, 12'h004);
            begin
                repeat (150) @(posedge clk);
                check(40'(dev.reFalls - base), 40'h2);
                check(40'(rdValid), 40'h1);
                rdReady <= 1'b1;
            end
        join
        repeat (4) @(posedge clk);
        check(40'(got.size()), 40'h4);
        for (k = 0; k < 4; k++)
            check(40'(got[k][7:0]), 40'(8'(8'h5f + k) ^ 8'ha5));
        $display("test stalled read done");

        cmd(8'h60);
        run(nand_host_pkg::OP_ADDR, 8'h00, 12'h000, 17'h00040, 12'h000);
        cmd(8'hd0);
        cmd(8'h70);
        check(40'(dev.lastCmd), 40'h70);
        refused(nand_host_pkg::OP_CMD, 8'h90);
        check(40'(took), 40'h0);
        waitReady();
        $display("test busy done");

        protect <= 1'b1;
        repeat (2) @(negedge clk);
        check(40'(nandCtl.wpN), 40'h0);
        refused(nand_host_pkg::OP_CMD, 8'h80);
        check(40'(took), 40'h0);
        refused(nand_host_pkg::OP_WRITE, 8'h00);
        check(40'(took), 40'h0);
        protect <= 1'b0;
        refused(nand_host_pkg::OP_CMD, 8'h7b);
        check(40'(took), 40'h0);
        cmd(8'h80);
        run(nand_host_pkg::OP_ADDR, 8'h00, 12'h010, 17'h00080, 12'h000);
        wrData <= 16'h0040;
        wrValid <= 1'b1;
        run(nand_host_pkg::OP_WRITE, 8'h00, 12'h000, 17'h00000, 12'h003);
        wrValid <= 1'b0;
        cmd(8'h10);
        waitReady();
        check(40'(dev.wrCount), 40'h3);
        check(40'(dev.lastWord[7:0]), 40'h42);
        $display("test program done");
        test_done();
    end
endmodule // tb_top
`default_nettype wire
